// ### fcrd_datapath.sv
// cipher, repeat filter, data stream generator and framer loopback datapath
//
// What this block does
// - cipher generator is 11 stages, stage one fed by stage 11 xor stage 9.
// - with scrambling on, each encoded bit is xored with generator output.
// - no pattern match: output is received xor generator, generator open loop.
// - hypothesis bit is received bit xor itself delayed eleven and nine bits.
// - all-zero or all-one hypothesis window forces all-zero or all-one data.
// - halt and master hypothesis patterns yield their fixed data patterns.
// - on a match generator input is deduced data xor received bit.
// - synchronizer acts only while resync request is high, else free-runs.
// - scrambler enabled by enable pin or cipher register bit 0.
// - repeat filter takes the remote loopback stream, one pair per clock.
// - invalid line states are replaced by continuous Idle pairs.
// - corrupted frame gets four Halts, then Idles until a J-K pair.
// - Idle inside a frame overwrites the delayed previous pair with Idles.
// - stream generator picks request, maintenance bits, filter or data.
// - stream generator registers its pair every clock for the erase delay.
// - normally the framer gets the descrambled receive input latch.
// - loopback bit or self test feeds transmit output latch to the framer.
// - every internal path carries one ten-bit symbol pair.
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "fcrd_regs.svh"

module fcrd_datapath (
	// clock and reset
	input  wire logic            core_clk_in,
	input  wire logic            arst_n_in,
	// apb slave
	input  wire logic            psel_in,
	input  wire logic            penable_in,
	input  wire logic            pwrite_in,
	input  wire logic [11:0]     paddr_in,
	input  wire logic [31:0]     pwdata_in,
	output logic                 pready_out,
	output logic                 pslverr_out,
	output logic [31:0]          prdata_out,
	// pins and control from neighbouring logic
	input  wire logic            scrambler_enable_pin_in,
	input  wire logic            descrambler_resync_request_in,
	input  wire logic            maintenance_state_in,
	input  wire logic            self_test_run_in,
	input  wire logic [2:0]      line_state_request_bus_in,
	// receive path
	input  wire logic [9:0]      rx_line_pair_in,
	output logic [9:0]           framer_pair_out,
	// transmit path
	input  wire logic [9:0]      rf_source_pair_in,
	output logic [9:0]           encoder_input_stream_out,
	input  wire logic [9:0]      tx_encoded_pair_in,
	output logic [9:0]           tx_line_pair_out,
	// observation
	output logic [1:0]           repeat_filter_control_out
);

	fcrd_pkg::fcrd_state_t s_q;
	fcrd_pkg::fcrd_state_t s_d;
	fcrd_pkg::fcrd_apb_req_t req;
	fcrd_pkg::fcrd_rf_ctl_t rfc;

	// printed patterns and reset words kept whole so single bits can be taken
	localparam logic [10:0] D_HALT   = `FCRD_D_HALT;
	localparam logic [10:0] D_MASTER = `FCRD_D_MASTER;
	localparam logic [31:0] RST_A    = `FCRD_RST_CTRL_A;
	localparam logic [31:0] RST_B    = `FCRD_RST_CTRL_B;
	localparam logic [31:0] RST_C    = `FCRD_RST_CTRL_C;

	// bit-serial scrambler over one pair, bit 9 leaves first
	function automatic fcrd_pkg::fcrd_scr_t scramble(
		input logic [10:0] gen,
		input logic [9:0]  din,
		input logic        en);
		fcrd_pkg::fcrd_scr_t r;
		logic fb;
		r.gen = gen;
		r.data = din;
		for (int b = 9; b >= 0; b--) begin
			fb = r.gen[10] ^ r.gen[8];
			r.gen = {r.gen[9:0], fb};
			if (en) begin
				r.data[b] = din[b] ^ fb;
			end
		end
		return r;
	endfunction

	// bit-serial descrambler with line-state synchronizer
	function automatic fcrd_pkg::fcrd_dsc_t descramble(
		input fcrd_pkg::fcrd_dsc_t st,
		input logic [9:0]          din,
		input logic                resync);
		fcrd_pkg::fcrd_dsc_t r;
		logic sb;
		logic fb;
		logic h;
		logic d;
		logic hit;
		r = st;
		r.match = 1'b0;
		for (int b = 9; b >= 0; b--) begin
			sb = din[b];
			h = sb ^ r.hist[10] ^ r.hist[8];
			r.hwin = {r.hwin[9:0], h};
			r.hist = {r.hist[9:0], sb};
			fb = r.gen[10] ^ r.gen[8];
			hit = 1'b1;
			d = sb ^ fb;
			case (r.hwin)
				`FCRD_H_QUIET:  d = 1'b0;
				`FCRD_H_IDLE:   d = 1'b1;
				// deduced bit is the newest, lowest bit of the pattern
				`FCRD_H_HALT:   d = D_HALT[0];
				`FCRD_H_MASTER: d = D_MASTER[0];
				default:        hit = 1'b0;
			endcase
			// outside resync the generator is trusted and free-runs
			if (!resync) begin
				hit = 1'b0;
				d = sb ^ fb;
			end
			r.gen = {r.gen[9:0], hit ? (d ^ sb) : fb};
			r.data[b] = d;
			r.match = r.match | hit;
		end
		return r;
	endfunction

	function automatic logic [9:0] ls_pair(input logic [2:0] code);
		case (code)
			`FCRD_LS_QUIET:  ls_pair = {`FCRD_SYM_Q, `FCRD_SYM_Q};
			`FCRD_LS_IDLE:   ls_pair = {`FCRD_SYM_I, `FCRD_SYM_I};
			`FCRD_LS_HALT:   ls_pair = {`FCRD_SYM_H, `FCRD_SYM_H};
			`FCRD_LS_MASTER: ls_pair = {`FCRD_SYM_H, `FCRD_SYM_Q};
			default:         ls_pair = {`FCRD_SYM_I, `FCRD_SYM_I};
		endcase
	endfunction

	function automatic logic is_data(input logic [4:0] sym);
		is_data = ~sym[4];
	endfunction

	function automatic logic is_frame_ctl(input logic [4:0] sym);
		is_frame_ctl = (sym == `FCRD_SYM_R) || (sym == `FCRD_SYM_S)
			|| (sym == `FCRD_SYM_T);
	endfunction

	localparam logic [9:0] IDLE_PAIR = {`FCRD_SYM_I, `FCRD_SYM_I};
	localparam logic [9:0] HALT_PAIR = {`FCRD_SYM_H, `FCRD_SYM_H};
	localparam logic [9:0] JK_PAIR = {`FCRD_SYM_J, `FCRD_SYM_K};

	always_comb begin
		req.psel = psel_in;
		req.penable = penable_in;
		req.pwrite = pwrite_in;
		req.paddr = paddr_in;
		req.pwdata = pwdata_in;
	end

	always_comb begin
		logic        cipher_on;
		logic        acc;
		logic        wr;
		logic [4:0]  hi;
		logic [4:0]  lo;
		logic [9:0]  sel;
		fcrd_pkg::fcrd_scr_t sc;
		cipher_on = 1'b0;
		acc = 1'b0;
		wr = 1'b0;
		hi = rf_source_pair_in[9:5];
		lo = rf_source_pair_in[4:0];
		sel = rf_source_pair_in;
		sc = '0;
		rfc = fcrd_pkg::RFC_PASS;
		s_d = s_q;

		// enable pin passes two flops before use
		s_d.pin_sync = {s_q.pin_sync[0], scrambler_enable_pin_in};
		cipher_on = s_q.pin_sync[1] | s_q.cipher_en;

		// apb: one wait state, answer registered on the second access cycle
		acc = req.psel & req.penable & ~s_q.rsp.pready;
		wr = req.psel & req.penable & s_q.rsp.pready & req.pwrite;
		s_d.rsp.pready = acc;
		s_d.rsp.pslverr = 1'b0;
		s_d.rsp.prdata = 32'h0000_0000;
		if (acc) begin
			case (req.paddr)
				`FCRD_OFS_CTRL_A:
					s_d.rsp.prdata[`FCRD_A_FLOOP_BIT] = s_q.floop;
				`FCRD_OFS_CTRL_B:
					s_d.rsp.prdata[`FCRD_B_MAINTENANCE_STATE_LSB +: 3] = s_q.maintenance_state_line_state_bits;
				`FCRD_OFS_CTRL_C:
					s_d.rsp.prdata[`FCRD_C_CIPHER_BIT] = s_q.cipher_en;
				`FCRD_OFS_STATUS: begin
					s_d.rsp.prdata[`FCRD_ST_CIPHER_BIT] = cipher_on;
					s_d.rsp.prdata[`FCRD_ST_RESYNC_BIT] =
						descrambler_resync_request_in;
					s_d.rsp.prdata[`FCRD_ST_MATCH_BIT] = s_q.match_seen;
					s_d.rsp.prdata[`FCRD_ST_RF_LSB +: 4] = s_q.rf;
				end
				default: s_d.rsp.pslverr = 1'b1;
			endcase
		end
		if (wr) begin
			case (req.paddr)
				`FCRD_OFS_CTRL_A:
					s_d.floop = req.pwdata[`FCRD_A_FLOOP_BIT];
				`FCRD_OFS_CTRL_B:
					s_d.maintenance_state_line_state_bits = req.pwdata[`FCRD_B_MAINTENANCE_STATE_LSB +: 3];
				`FCRD_OFS_CTRL_C:
					s_d.cipher_en = req.pwdata[`FCRD_C_CIPHER_BIT];
				default: ;
			endcase
		end

		// receive side: descramble the receive input latch
		s_d.dsc = descramble(s_q.dsc, rx_line_pair_in,
			descrambler_resync_request_in);
		if (!cipher_on) begin
			s_d.dsc.data = rx_line_pair_in;
		end
		// a match on this pair wins over a status read clearing the bit
		s_d.match_seen = (s_q.match_seen & ~(acc & ~req.pwrite
			& (req.paddr == `FCRD_OFS_STATUS))) | (cipher_on & s_d.dsc.match);

		// transmit side: scrambler output latch and unscrambled copy
		sc = scramble(s_q.scr_gen, tx_encoded_pair_in, cipher_on);
		s_d.scr_gen = sc.gen;
		s_d.tx_line = sc.data;
		s_d.tx_out_latch = tx_encoded_pair_in;

		// framer input loopback, bypassing both cipher halves
		if (s_q.floop | self_test_run_in) begin
			s_d.framer = s_q.tx_out_latch;
		end else begin
			s_d.framer = s_q.dsc.data;
		end

		// repeat filter, one pair per clock
		case (s_q.rf)
			fcrd_pkg::RF_OUTSIDE: begin
				if (rf_source_pair_in == JK_PAIR) begin
					s_d.rf = fcrd_pkg::RF_FRAME;
				end else if (hi == `FCRD_SYM_I || hi == `FCRD_SYM_Q
					|| hi == `FCRD_SYM_H) begin
					if (lo != hi) begin
						rfc = fcrd_pkg::RFC_IDLE;
					end
				end else begin
					rfc = fcrd_pkg::RFC_IDLE;
				end
			end
			fcrd_pkg::RF_FRAME: begin
				if (hi == `FCRD_SYM_I || lo == `FCRD_SYM_I) begin
					rfc = fcrd_pkg::RFC_GOBBLE;
					s_d.rf = fcrd_pkg::RF_OUTSIDE;
				end else if (hi == `FCRD_SYM_T || lo == `FCRD_SYM_T) begin
					s_d.rf = fcrd_pkg::RF_OUTSIDE;
				end else if (!((is_data(hi) || is_frame_ctl(hi))
					&& (is_data(lo) || is_frame_ctl(lo)))) begin
					// corrupted: first of the halt pairs goes out now
					rfc = fcrd_pkg::RFC_HALT;
					s_d.halt_cnt = `FCRD_HALT_PAIRS - 2'h1;
					s_d.rf = fcrd_pkg::RF_HALT;
				end
			end
			fcrd_pkg::RF_HALT: begin
				rfc = fcrd_pkg::RFC_HALT;
				s_d.halt_cnt = s_q.halt_cnt - 2'h1;
				if (s_q.halt_cnt == 2'h1) begin
					s_d.rf = fcrd_pkg::RF_WAITJK;
				end
			end
			fcrd_pkg::RF_WAITJK: begin
				if (rf_source_pair_in == JK_PAIR) begin
					s_d.rf = fcrd_pkg::RF_FRAME;
				end else begin
					rfc = fcrd_pkg::RFC_IDLE;
				end
			end
			default: s_d.rf = fcrd_pkg::RF_OUTSIDE;
		endcase

		// data stream generator source priority
		if (maintenance_state_in && s_q.maintenance_state_line_state_bits != `FCRD_LS_NONE) begin
			sel = ls_pair(s_q.maintenance_state_line_state_bits);
		end else if (!maintenance_state_in
			&& line_state_request_bus_in != `FCRD_LS_NONE) begin
			sel = ls_pair(line_state_request_bus_in);
		end else begin
			case (rfc)
				fcrd_pkg::RFC_IDLE:   sel = IDLE_PAIR;
				fcrd_pkg::RFC_HALT:   sel = HALT_PAIR;
				fcrd_pkg::RFC_GOBBLE: sel = IDLE_PAIR;
				default:              sel = rf_source_pair_in;
			endcase
		end

		// two pair registers so a fragment can erase the pair before it
		s_d.dly = sel;
		if (rfc == fcrd_pkg::RFC_GOBBLE) begin
			s_d.stream = IDLE_PAIR;
		end else begin
			s_d.stream = s_q.dly;
		end
	end

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s_q <= '0;
			s_q.floop <= RST_A[`FCRD_A_FLOOP_BIT];
			s_q.maintenance_state_line_state_bits <= RST_B[`FCRD_B_MAINTENANCE_STATE_LSB +: 3];
			s_q.cipher_en <= RST_C[`FCRD_C_CIPHER_BIT];
			s_q.rf <= fcrd_pkg::RF_OUTSIDE;
			s_q.dly <= IDLE_PAIR;
			s_q.stream <= IDLE_PAIR;
		end else begin
			s_q <= s_d;
		end
	end

	// repeat filter control seen one cycle late, straight from a flop
	logic [1:0] rfc_q;
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rfc_q <= 2'h0;
		end else begin
			rfc_q <= rfc;
		end
	end

	assign pready_out = s_q.rsp.pready;
	assign pslverr_out = s_q.rsp.pslverr;
	assign prdata_out = s_q.rsp.prdata;
	assign framer_pair_out = s_q.framer;
	assign encoder_input_stream_out = s_q.stream;
	assign tx_line_pair_out = s_q.tx_line;
	assign repeat_filter_control_out = rfc_q;

endmodule
`default_nettype wire

// ### fcrd_regs.svh
// register map, field positions, symbol codes and cipher patterns
`ifndef FCRD_REGS_SVH
`define FCRD_REGS_SVH

`define FCRD_OFS_CTRL_A      12'h000
`define FCRD_OFS_CTRL_B      12'h004
`define FCRD_OFS_CTRL_C      12'h008
`define FCRD_OFS_STATUS      12'h00C

`define FCRD_A_FLOOP_BIT     0
`define FCRD_B_MAINTENANCE_STATE_LSB     0
`define FCRD_C_CIPHER_BIT    0
`define FCRD_RST_CTRL_A      32'h0000_0000
`define FCRD_RST_CTRL_B      32'h0000_0000
`define FCRD_RST_CTRL_C      32'h0000_0000

`define FCRD_ST_CIPHER_BIT   0
`define FCRD_ST_RESYNC_BIT   1
`define FCRD_ST_MATCH_BIT    2
`define FCRD_ST_RF_LSB       3

`define FCRD_SYM_Q           5'h10
`define FCRD_SYM_I           5'h17
`define FCRD_SYM_H           5'h14
`define FCRD_SYM_J           5'h1C
`define FCRD_SYM_K           5'h13
`define FCRD_SYM_T           5'h1D
`define FCRD_SYM_R           5'h11
`define FCRD_SYM_S           5'h19

`define FCRD_LS_NONE         3'h0
`define FCRD_LS_QUIET        3'h1
`define FCRD_LS_IDLE         3'h2
`define FCRD_LS_HALT         3'h3
`define FCRD_LS_MASTER       3'h4

`define FCRD_H_QUIET         11'h000
`define FCRD_H_IDLE          11'h7FF
`define FCRD_H_HALT          11'h39C
`define FCRD_D_HALT          11'h108
`define FCRD_H_MASTER        11'h380
`define FCRD_D_MASTER        11'h100

`define FCRD_HALT_PAIRS      2'h2

`endif

// ### fcrd_pkg.sv
// types shared by the cipher and repeat datapath
package fcrd_pkg;

	typedef enum logic [3:0] {
		RF_OUTSIDE = 4'b0001,
		RF_FRAME   = 4'b0010,
		RF_HALT    = 4'b0100,
		RF_WAITJK  = 4'b1000
	} fcrd_rf_state_t;

	typedef enum logic [1:0] {
		RFC_PASS   = 2'h0,
		RFC_IDLE   = 2'h1,
		RFC_HALT   = 2'h2,
		RFC_GOBBLE = 2'h3
	} fcrd_rf_ctl_t;

	typedef struct packed {
		logic [10:0] gen;
		logic [10:0] hist;
		logic [10:0] hwin;
		logic [9:0]  data;
		logic        match;
	} fcrd_dsc_t;

	typedef struct packed {
		logic [10:0] gen;
		logic [9:0]  data;
	} fcrd_scr_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} fcrd_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} fcrd_apb_rsp_t;

	typedef struct packed {
		logic           floop;
		logic [2:0]     maintenance_state_line_state_bits;
		logic           cipher_en;
		logic [1:0]     pin_sync;
		logic           match_seen;
		fcrd_dsc_t      dsc;
		logic [10:0]    scr_gen;
		logic [9:0]     tx_out_latch;
		logic [9:0]     tx_line;
		logic [9:0]     framer;
		fcrd_rf_state_t rf;
		logic [1:0]     halt_cnt;
		logic [9:0]     dly;
		logic [9:0]     stream;
		fcrd_apb_rsp_t  rsp;
	} fcrd_state_t;

endpackage

// ### fcrd_datapath_assertions.sv
// port assertions for the cipher and repeat datapath
`timescale 1ns/1ps
`default_nettype none
`include "fcrd_regs.svh"
module fcrd_datapath_chk (
	// clock and reset
	input wire logic        core_clk_in,
	input wire logic        arst_n_in,
	// apb
	input wire logic        psel_in,
	input wire logic        penable_in,
	input wire logic        pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic        pready_out,
	input wire logic        pslverr_out,
	input wire logic [31:0] prdata_out,
	// control
	input wire logic        scrambler_enable_pin_in,
	input wire logic        maintenance_state_in,
	input wire logic        self_test_run_in,
	input wire logic [2:0]  line_state_request_bus_in,
	// pairs
	input wire logic [9:0]  tx_encoded_pair_in,
	input wire logic [9:0]  framer_pair_out,
	input wire logic [9:0]  tx_line_pair_out,
	input wire logic [9:0]  encoder_input_stream_out,
	input wire logic [1:0]  repeat_filter_control_out
);
	logic       ciph_q;
	logic [2:0] low_cnt_q;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!arst_n_in);

	function automatic logic [9:0] ls_pair(input logic [2:0] c);
		case (c)
			3'h1: ls_pair = {`FCRD_SYM_Q, `FCRD_SYM_Q};
			3'h2: ls_pair = {`FCRD_SYM_I, `FCRD_SYM_I};
			3'h3: ls_pair = {`FCRD_SYM_H, `FCRD_SYM_H};
			3'h4: ls_pair = {`FCRD_SYM_H, `FCRD_SYM_Q};
			default: ls_pair = {`FCRD_SYM_I, `FCRD_SYM_I};
		endcase
	endfunction

	// pin passes a synchroniser, so plain mode is judged only after it settles
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ciph_q    <= 1'b0;
			low_cnt_q <= 3'h0;
		end else begin
			if (psel_in && penable_in && pready_out && pwrite_in &&
			    paddr_in == `FCRD_OFS_CTRL_C)
				ciph_q <= pwdata_in[0];
			if (scrambler_enable_pin_in)
				low_cnt_q <= 3'h0;
			else if (low_cnt_q != 3'h7)
				low_cnt_q <= low_cnt_q + 3'h1;
		end
	end

	property p_ans;
		psel_in && penable_in && !pready_out |=> pready_out;
	endproperty
	property p_pulse;
		pready_out |=> !pready_out;
	endproperty
	property p_err;
		pslverr_out |-> pready_out;
	endproperty
	property p_rdz;
		!pready_out |-> prdata_out == 32'h0;
	endproperty
	property p_unm;
		psel_in && penable_in && !pready_out && paddr_in > `FCRD_OFS_STATUS
		|=> pslverr_out;
	endproperty
	property p_plain;
		low_cnt_q >= 3'h5 && !ciph_q && !$past(ciph_q) && !$past(ciph_q, 2)
		|-> tx_line_pair_out == $past(tx_encoded_pair_in);
	endproperty
	property p_loop;
		self_test_run_in [*3]
		|=> framer_pair_out == $past(tx_encoded_pair_in, 2);
	endproperty
	property p_req;
		$past(arst_n_in) && $past(arst_n_in, 2) &&
		$past(line_state_request_bus_in) != 3'h0 &&
		$past(line_state_request_bus_in) == $past(line_state_request_bus_in, 2)
		&& !$past(maintenance_state_in) && !$past(maintenance_state_in, 2)
		|-> encoder_input_stream_out == ls_pair($past(line_state_request_bus_in));
	endproperty
	property p_halt;
		$rose(repeat_filter_control_out == fcrd_pkg::RFC_HALT)
		|=> repeat_filter_control_out == fcrd_pkg::RFC_HALT
		##1 repeat_filter_control_out != fcrd_pkg::RFC_HALT;
	endproperty

	a_ans: assert property (p_ans) else $error("no answer");
	a_pulse: assert property (p_pulse) else $error("ready held");
	a_err: assert property (p_err) else $error("error alone");
	a_rdz: assert property (p_rdz) else $error("stale rdata");
	a_unm: assert property (p_unm) else $error("unmapped ok");
	a_plain: assert property (p_plain) else $error("scrambled");
	a_loop: assert property (p_loop) else $error("no loopback");
	a_req: assert property (p_req) else $error("bad request pair");
	a_halt: assert property (p_halt) else $error("halt count");

	c_halt: cover property ($rose(repeat_filter_control_out == 2'h2));
	c_err: cover property (pslverr_out);
	c_loop: cover property (self_test_run_in [*3]);
endmodule

bind fcrd_datapath fcrd_datapath_chk u_chk (
	.core_clk_in               (core_clk_in),
	.arst_n_in                 (arst_n_in),
	.psel_in                   (psel_in),
	.penable_in                (penable_in),
	.pwrite_in                 (pwrite_in),
	.paddr_in                  (paddr_in),
	.pwdata_in                 (pwdata_in),
	.pready_out                (pready_out),
	.pslverr_out               (pslverr_out),
	.prdata_out                (prdata_out),
	.scrambler_enable_pin_in   (scrambler_enable_pin_in),
	.maintenance_state_in      (maintenance_state_in),
	.self_test_run_in          (self_test_run_in),
	.line_state_request_bus_in (line_state_request_bus_in),
	.tx_encoded_pair_in        (tx_encoded_pair_in),
	.framer_pair_out           (framer_pair_out),
	.tx_line_pair_out          (tx_line_pair_out),
	.encoder_input_stream_out  (encoder_input_stream_out),
	.repeat_filter_control_out (repeat_filter_control_out)
);
`default_nettype wire

// ### fcrd_mac_model.sv
// mac-side partner: sends encoded pairs and loops the line back
`timescale 1ns/1ps
`default_nettype none
module fcrd_mac_model (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	// pairs
	input  wire logic [9:0] pair_in,
	input  wire logic [9:0] line_in,
	output logic [9:0]      enc_out,
	output logic [9:0]      rx_out
);
	// whole pairs only, never a lone symbol
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			enc_out <= 10'h000;
			rx_out  <= 10'h000;
		end else begin
			enc_out <= pair_in;
			rx_out  <= line_in;
		end
	end
endmodule
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the cipher and repeat datapath
`timescale 1ns/1ps
`default_nettype none
`include "fcrd_regs.svh"
module tb_top;
	typedef struct packed {
		logic       m;
		logic [2:0] mc;
		logic [2:0] rq;
		logic [9:0] rf;
		logic [9:0] ex;
	} fcrd_row_t;
	logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, er;
	logic        pin, resync, maintenance_state, st;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0]  req;
	logic [1:0]  rfc;
	logic [9:0]  rx, framer, rf, enc, txline, stream, pair;
	logic [9:0]  seq [12];
	logic [9:0]  wv [3];
	int          cnt [4];
	int          miscompares, comparisons, cycles;
	fcrd_row_t   rows [10] = '{
		'{1'b0, 3'h0, 3'h1, 10'h2F7, 10'h210},
		'{1'b0, 3'h0, 3'h2, 10'h012, 10'h2F7},
		'{1'b0, 3'h0, 3'h3, 10'h2F7, 10'h294},
		'{1'b0, 3'h0, 3'h4, 10'h2F7, 10'h290},
		'{1'b1, 3'h1, 3'h2, 10'h2F7, 10'h210},
		'{1'b1, 3'h2, 3'h1, 10'h2F7, 10'h2F7},
		'{1'b1, 3'h3, 3'h0, 10'h2F7, 10'h294},
		'{1'b1, 3'h4, 3'h0, 10'h2F7, 10'h290},
		'{1'b1, 3'h0, 3'h2, 10'h318, 10'h2F7},
		'{1'b0, 3'h0, 3'h0, 10'h012, 10'h2F7}};

	fcrd_datapath DUT (
		.core_clk_in                   (clk),
		.arst_n_in                     (arst_n),
		.psel_in                       (psel),
		.penable_in                    (penable),
		.pwrite_in                     (pwrite),
		.paddr_in                      (paddr),
		.pwdata_in                     (pwdata),
		.pready_out                    (pready),
		.pslverr_out                   (pslverr),
		.prdata_out                    (prdata),
		.scrambler_enable_pin_in       (pin),
		.descrambler_resync_request_in (resync),
		.maintenance_state_in          (maintenance_state),
		.self_test_run_in              (st),
		.line_state_request_bus_in     (req),
		.rx_line_pair_in               (rx),
		.framer_pair_out               (framer),
		.rf_source_pair_in             (rf),
		.encoder_input_stream_out      (stream),
		.tx_encoded_pair_in            (enc),
		.tx_line_pair_out              (txline),
		.repeat_filter_control_out     (rfc)
	);
	fcrd_mac_model u_mac (
		.clk_in   (clk),
		.rst_n_in (arst_n),
		.pair_in  (pair),
		.line_in  (txline),
		.enc_out  (enc),
		.rx_out   (rx)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task tally_and_finish;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			miscompares++;
			tally_and_finish;
		end
	end

	task chk(input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			miscompares++;
			$display("mismatch at %0t: saw %h want %h", $time, s, x);
		end
	endtask

	// idle cycle first so a release and a new setup never share a step
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rdchk(input logic [11:0] a, input logic [31:0] x, input logic e);
		apb(1'b0, a, 32'h0);
		chk(rd, x);
		chk({31'h0, er}, {31'h0, e});
	endtask

	task feed;
		for (int k = 0; k < 15; k++) begin
			@(posedge clk);
			rf <= (k < 12) ? seq[k] : 10'h2F7;
			for (int j = 0; j < 3; j++)
				if (stream === wv[j])
					cnt[j]++;
			if (rfc === 2'h3)
				cnt[3]++;
		end
	endtask

	initial begin
		{arst_n, psel, penable, pwrite, pin, resync, maintenance_state, st} = 8'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		req = 3'h0;
		rf = 10'h2F7;
		pair = 10'h000;
		miscompares = 0;
		comparisons = 0;
		cycles = 0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		chk(stream, 10'h2F7);
		chk(txline, 10'h000);
		rdchk(`FCRD_OFS_CTRL_A, 32'h0, 1'b0);
		rdchk(`FCRD_OFS_CTRL_C, 32'h0, 1'b0);
		rdchk(12'h018, 32'h0, 1'b1);
		foreach (rows[i]) begin
			maintenance_state <= rows[i].m;
			req <= rows[i].rq;
			rf <= rows[i].rf;
			wr(`FCRD_OFS_CTRL_B, {29'h0, rows[i].mc});
			repeat (3) @(posedge clk);
			chk(stream, rows[i].ex);
		end
		maintenance_state <= 1'b0;
		wr(`FCRD_OFS_CTRL_B, 32'h0);
		// data pairs keep the control bit of each symbol low
		seq = '{10'h2F7, 10'h2F7, 10'h393, 10'h022, 10'h318, 10'h064,
			10'h0A6, 10'h2F7, 10'h2F7, 10'h393, 10'h022, 10'h022};
		wv = '{10'h294, 10'h064, 10'h393};
		cnt = '{0, 0, 0, 0};
		feed;
		chk(cnt[0], 2);
		chk(cnt[1], 0);
		chk(cnt[2], 2);
		chk(cnt[3], 1);
		seq = '{10'h2F7, 10'h393, 10'h022, 10'h064, 10'h2F7, 10'h2F7,
			10'h2F7, 10'h2F7, 10'h2F7, 10'h2F7, 10'h2F7, 10'h2F7};
		wv = '{10'h064, 10'h022, 10'h393};
		cnt = '{0, 0, 0, 0};
		feed;
		chk(cnt[0], 0);
		chk(cnt[1], 1);
		chk(cnt[2], 1);
		chk(cnt[3], 1);
		pin <= 1'b1;
		pair <= 10'h0A5;
		wr(`FCRD_OFS_CTRL_A, 32'h1);
		repeat (4) @(posedge clk);
		chk(framer, 10'h0A5);
		wr(`FCRD_OFS_CTRL_A, 32'h0);
		st <= 1'b1;
		repeat (4) @(posedge clk);
		chk(framer, 10'h0A5);
		st <= 1'b0;
		pin <= 1'b0;
		pair <= 10'h3FF;
		resync <= 1'b1;
		wr(`FCRD_OFS_CTRL_C, 32'h1);
		rdchk(`FCRD_OFS_CTRL_C, 32'h1, 1'b0);
		repeat (20) @(posedge clk);
		chk(framer, 10'h3FF);
		resync <= 1'b0;
		repeat (6) @(posedge clk);
		chk(framer, 10'h3FF);
		// sticky match bit is set by the resync phase, then read clears it
		rdchk(`FCRD_OFS_STATUS, 32'h0000_000D, 1'b0);
		rdchk(`FCRD_OFS_STATUS, 32'h0000_0009, 1'b0);
		pair <= 10'h155;
		repeat (8) @(posedge clk);
		chk(framer, 10'h155);
		pair <= 10'h2AA;
		repeat (8) @(posedge clk);
		chk(framer, 10'h2AA);
		wr(`FCRD_OFS_CTRL_C, 32'h0);
		tally_and_finish;
	end
endmodule
`default_nettype wire
